// ### rtl/hbp_host_port.v
// host controller driving the uart parallel bus port
`timescale 1ns/1ps
`include "hbp_defs.vh"
module hbp_host_port (
	input  wire       clk,                       // 50 MHz clock
	input  wire       rst_n,                     // sync reset, active low
	input  wire       muxed_bus_enable,          // strap: muxed address/data mode
	input  wire       bus_type_sel,              // strap: 1 strobe, 0 rw-line
	input  wire       req_valid,                 // access request
	output wire       req_ready,                 // controller idle
	input  wire       req_write,                 // 1 write, 0 read
	input  wire [2:0] req_addr,                  // register address
	input  wire [7:0] req_wdata,                 // write data
	output reg        rsp_valid_r,               // one-cycle access done
	output reg  [7:0] rsp_rdata_r,               // read data
	output reg        chip_select_n_r,           // chip select pin
	output reg        read_strobe_n_r,           // read strobe pin
	output reg        write_strobe_n_r,          // write strobe / direction pin
	output reg        address_latch_n_r,         // address latch pin
	output reg  [2:0] register_address_r,        // address pins
	output reg  [7:0] host_data_lines_o_r,       // data/shared lines out
	output reg        host_data_lines_oe_n_r,    // low while host drives
	input  wire [7:0] host_data_lines_i          // data/shared lines in
);
	localparam [5:0] S_IDLE  = 6'h01;
	localparam [5:0] S_ALE   = 6'h02;
	localparam [5:0] S_SETUP = 6'h04;
	localparam [5:0] S_STRB  = 6'h08;
	localparam [5:0] S_HOLD  = 6'h10;
	localparam [5:0] S_DONE  = 6'h20;
	// cycle counts are worked out as integers, then cut to the timer width
	localparam integer SETUP_I  = `HBP_SETUP_CYC;
	localparam integer STROBE_I = `HBP_STROBE_CYC;
	localparam integer HOLD_I   = `HBP_HOLD_CYC;
	localparam [3:0]   SETUP_C  = SETUP_I[3:0];
	localparam [3:0]   STROBE_C = STROBE_I[3:0];
	localparam [3:0]   HOLD_C   = HOLD_I[3:0];

	reg  [5:0] state_r;
	reg  [5:0] state_nxt;
	reg  [1:0] mode_r;
	reg        wr_r;
	reg  [2:0] addr_r;
	reg  [7:0] wdata_r;
	reg  [7:0] din_s1_r;
	reg  [7:0] din_s2_r;
	reg        load;
	reg  [3:0] load_cnt;
	wire       phase_done;

	////////////////////////////////////////////////////////////////
	function [1:0] pick_mode;
		input m;
		input b;
		begin
			if (m)
				pick_mode = `HBP_MODE_MUXED;
			else if (b)
				pick_mode = `HBP_MODE_STROBE;
			else
				pick_mode = `HBP_MODE_RWLINE;
		end
	endfunction

	hbp_phase_timer u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (load),
		.count (load_cnt),
		.done  (phase_done)
	);

	assign req_ready = (state_r == S_IDLE);

	// data lines pass two flops before use
	always @(posedge clk) begin
		din_s1_r <= host_data_lines_i;
		din_s2_r <= din_s1_r;
	end

	////////////////////////////////////////////////////////////////
	always @* begin
		state_nxt = state_r;
		load      = 1'b0;
		load_cnt  = SETUP_C;
		case (state_r)
			S_IDLE: begin
				if (req_valid) begin
					load = 1'b1;
					state_nxt = (pick_mode(muxed_bus_enable, bus_type_sel) ==
						`HBP_MODE_MUXED) ? S_ALE : S_SETUP;
				end
			end
			S_ALE: begin
				if (phase_done) begin
					load = 1'b1;
					state_nxt = S_SETUP;
				end
			end
			S_SETUP: begin
				if (phase_done) begin
					load = 1'b1;
					load_cnt = STROBE_C;
					state_nxt = S_STRB;
				end
			end
			S_STRB: begin
				if (phase_done) begin
					load = 1'b1;
					load_cnt = HOLD_C;
					state_nxt = S_HOLD;
				end
			end
			S_HOLD: begin
				if (phase_done)
					state_nxt = S_DONE;
			end
			S_DONE:  state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (!rst_n) begin
			state_r                <= S_IDLE;
			mode_r                 <= `HBP_MODE_STROBE;
			wr_r                   <= 1'b0;
			addr_r                 <= 3'h0;
			wdata_r                <= 8'h00;
			rsp_valid_r            <= 1'b0;
			rsp_rdata_r            <= 8'h00;
			chip_select_n_r        <= 1'b1;
			read_strobe_n_r        <= 1'b1;
			write_strobe_n_r       <= 1'b1;
			address_latch_n_r      <= 1'b1;
			register_address_r     <= 3'h0;
			host_data_lines_o_r    <= 8'h00;
			host_data_lines_oe_n_r <= 1'b1;
		end else begin
			state_r     <= state_nxt;
			rsp_valid_r <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (req_valid) begin
						mode_r  <= pick_mode(muxed_bus_enable, bus_type_sel);
						wr_r    <= req_write;
						addr_r  <= req_addr;
						wdata_r <= req_wdata;
						chip_select_n_r <= 1'b0;
						if (muxed_bus_enable) begin
							address_latch_n_r      <= 1'b0;
							host_data_lines_o_r    <= {5'h00, req_addr};
							host_data_lines_oe_n_r <= 1'b0;
						end else begin
							register_address_r <= req_addr;
							if (!bus_type_sel) begin
								write_strobe_n_r <= ~req_write;
								read_strobe_n_r  <= 1'b1;
							end
							if (req_write) begin
								host_data_lines_o_r    <= req_wdata;
								host_data_lines_oe_n_r <= 1'b0;
							end
						end
					end
				end
				S_ALE: begin
					if (phase_done) begin
						address_latch_n_r <= 1'b1;
						if (wr_r)
							host_data_lines_o_r <= wdata_r;
						else
							host_data_lines_oe_n_r <= 1'b1;
					end
				end
				S_SETUP: begin
					if (phase_done && mode_r != `HBP_MODE_RWLINE) begin
						if (wr_r)
							write_strobe_n_r <= 1'b0;
						else
							read_strobe_n_r <= 1'b0;
					end
				end
				S_STRB: begin
					if (phase_done) begin
						if (!wr_r)
							rsp_rdata_r <= din_s2_r;
						if (mode_r == `HBP_MODE_RWLINE)
							chip_select_n_r <= 1'b1;
						else begin
							read_strobe_n_r  <= 1'b1;
							write_strobe_n_r <= 1'b1;
						end
					end
				end
				S_HOLD: begin
					if (phase_done) begin
						chip_select_n_r        <= 1'b1;
						write_strobe_n_r       <= 1'b1;
						host_data_lines_oe_n_r <= 1'b1;
					end
				end
				S_DONE: rsp_valid_r <= 1'b1;
				default: ;
			endcase
		end
	end
endmodule // hbp_host_port

// ### rtl/hbp_phase_timer.v
// phase timer: counts a loaded number of cycles and pulses done
`timescale 1ns/1ps
module hbp_phase_timer (
	input  wire       clk,    // system clock
	input  wire       rst_n,  // sync reset, active low
	input  wire       load,   // start a new phase
	input  wire [3:0] count,  // phase length in cycles
	output wire       done    // high in last cycle of phase
);
	reg [3:0] cnt_r;
	always @(posedge clk) begin
		if (!rst_n)
			cnt_r <= 4'h0;
		else if (load)
			cnt_r <= count;
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
	end
	assign done = (cnt_r == 4'h1);
endmodule // hbp_phase_timer

// ### shared/hbp_defs.vh
// timing counts and mode codes for the host bus port controller
`ifndef HBP_DEFS_VH
`define HBP_DEFS_VH
`define HBP_CLK_NS        20
`define HBP_SETUP_NS      40
`define HBP_STROBE_NS     100
`define HBP_HOLD_NS       40
`define HBP_SETUP_CYC     ((`HBP_SETUP_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`define HBP_STROBE_CYC    ((`HBP_STROBE_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`define HBP_HOLD_CYC      ((`HBP_HOLD_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`define HBP_CNT_W         4
`define HBP_MODE_STROBE   2'h0
`define HBP_MODE_RWLINE   2'h1
`define HBP_MODE_MUXED    2'h2
`endif

// ### test/hbp_dev_model.sv
// behavioural uart bus port answering the controller
`timescale 1ns/1ps
module hbp_dev_model (
	input wire       muxed_bus_enable, // strap
	input wire       bus_type_sel,     // strap
	input wire       chip_select_n,    // pin
	input wire       read_strobe_n,    // pin
	input wire       write_strobe_n,   // pin
	input wire       address_latch_n,  // pin
	input wire [2:0] register_address, // pin
	input wire [7:0] host_out,         // host data
	input wire       host_oe_n,        // host drives
	output wire [7:0] bus              // wire level
);
	reg  [7:0] mem [0:7];
	reg  [7:0] last = 8'h00;
	reg  [2:0] la;
	wire [7:0] bus_d;
	wire       strobe = muxed_bus_enable | bus_type_sel;
	wire [2:0] ra = muxed_bus_enable ? la : register_address;
	wire       drv = !chip_select_n && (strobe ? !read_strobe_n : write_strobe_n);
	// released lines show the inverse of the last value
	assign bus = !host_oe_n ? host_out : drv ? mem[ra] : ~last;
	assign #1 bus_d = bus;
	always @(bus) if (!host_oe_n || drv) last = bus;
	always @(posedge address_latch_n) if (!chip_select_n && muxed_bus_enable) la <= bus_d[2:0];
	always @(posedge write_strobe_n) if (!chip_select_n && strobe) mem[ra] <= bus_d;
	always @(posedge chip_select_n) if (!strobe && !write_strobe_n) mem[ra] <= bus_d;
endmodule // hbp_dev_model

// ### test/hbp_host_port_monitor.sv
// assertion checker on the host bus port controller pins
`timescale 1ns/1ps
module hbp_host_port_monitor (
	input wire clk,                    // clock
	input wire rst_n,                  // reset
	input wire muxed_bus_enable,       // strap
	input wire bus_type_sel,           // strap
	input wire req_valid,              // request
	input wire req_ready,              // idle
	input wire req_write,              // write
	input wire chip_select_n_r,        // pin
	input wire read_strobe_n_r,        // pin
	input wire write_strobe_n_r,       // pin
	input wire address_latch_n_r,      // pin
	input wire host_data_lines_oe_n_r  // pin
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire acc = req_valid && req_ready;
	wire rwl = !muxed_bus_enable && !bus_type_sel;
	//////////////////////////////////////////////////////////////////////////////
	a_rd_in_frame: assert property (!read_strobe_n_r |-> !chip_select_n_r)
		else $error("read strobe outside chip select");
	a_rd_idle_line: assert property (rwl |-> read_strobe_n_r)
		else $error("read strobe used in line mode");
	a_no_drive_rd: assert property (!read_strobe_n_r |-> host_data_lines_oe_n_r)
		else $error("host drives lines during read");
	a_wr_in_frame: assert property (!write_strobe_n_r && !rwl |-> !chip_select_n_r)
		else $error("write strobe outside chip select");
	a_dir_follows: assert property (acc && rwl |=> write_strobe_n_r == !$past(req_write))
		else $error("direction line wrong");
	a_latch_pulse: assert property (acc && muxed_bus_enable |=> !address_latch_n_r [*2] ##1 address_latch_n_r)
		else $error("address latch pulse wrong");
	cover property (acc && bus_type_sel && !muxed_bus_enable);
	cover property (acc && rwl);
	cover property (acc && muxed_bus_enable);
endmodule // hbp_host_port_monitor
bind hbp_host_port hbp_host_port_monitor u_mon (.clk, .rst_n, .muxed_bus_enable, .bus_type_sel,
	.req_valid, .req_ready, .req_write, .chip_select_n_r, .read_strobe_n_r, .write_strobe_n_r,
	.address_latch_n_r, .host_data_lines_oe_n_r);

// ### test/hbp_host_port_test.sv
// self-checking bench for the host bus port controller
`timescale 1ns/1ps
module hbp_host_port_test;
	reg        clk = 1'b0, rst_n = 1'b0, mux = 1'b0, bts = 1'b1;
	reg        req_valid = 1'b0, req_write = 1'b0;
	reg  [2:0] req_addr = 3'h0;
	reg  [7:0] req_wdata = 8'h00;
	wire       req_ready, rsp_valid_r, cs_n, rd_n, wr_n, ale_n, hd_oe_n;
	wire [2:0] ra;
	wire [7:0] rsp_rdata_r, hd_o, hd_i;
	integer    error_cnt = 0, total_checks = 0;
	always #10 clk = ~clk;
	hbp_host_port DUT (.clk(clk), .rst_n(rst_n), .muxed_bus_enable(mux), .bus_type_sel(bts),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .rsp_valid_r(rsp_valid_r), .rsp_rdata_r(rsp_rdata_r),
		.chip_select_n_r(cs_n), .read_strobe_n_r(rd_n), .write_strobe_n_r(wr_n),
		.address_latch_n_r(ale_n), .register_address_r(ra), .host_data_lines_o_r(hd_o),
		.host_data_lines_oe_n_r(hd_oe_n), .host_data_lines_i(hd_i));
	hbp_dev_model u_dev (.muxed_bus_enable(mux), .bus_type_sel(bts), .chip_select_n(cs_n),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .address_latch_n(ale_n),
		.register_address(ra), .host_out(hd_o), .host_oe_n(hd_oe_n), .bus(hd_i));
	//////////////////////////////////////////////////////////////////////////////
	task chk(input [7:0] got, input [7:0] exp);
	begin
		total_checks = total_checks + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task test_done;
	begin
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	end
	endtask
	// one access; read data compared with d, answer time with lat
	task acc(input w, input [2:0] a, input [7:0] d, input [7:0] lat);
		integer n;
	begin
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge clk);
		req_valid <= 1'b0;
		n = 1;
		while (rsp_valid_r !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n = n + 1;
		end
		chk(n, lat);
		if (!w) chk(rsp_rdata_r, d);
	end
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task t_strobe;
	begin
		chk({req_ready, cs_n, rd_n, wr_n, ale_n, hd_oe_n, rsp_valid_r}, 8'h7e);
		acc(1'b1, 3'h0, 8'ha5, 8'h0b);
		acc(1'b1, 3'h7, 8'h3c, 8'h0b);
		acc(1'b0, 3'h7, 8'h3c, 8'h0b);
		acc(1'b0, 3'h0, 8'ha5, 8'h0b);
		chk({cs_n, hd_oe_n}, 8'h03);
	end
	endtask
	task t_rwline;
	begin
		@(posedge clk);
		bts <= 1'b0;
		acc(1'b1, 3'h2, 8'h5a, 8'h0b);
		acc(1'b0, 3'h2, 8'h5a, 8'h0b);
		acc(1'b0, 3'h7, 8'h3c, 8'h0b);
	end
	endtask
	task t_muxed;
	begin
		@(posedge clk);
		mux <= 1'b1;
		acc(1'b1, 3'h5, 8'hc3, 8'h0d);
		acc(1'b0, 3'h5, 8'hc3, 8'h0d);
		@(posedge clk);
		bts <= 1'b1;
		acc(1'b0, 3'h0, 8'ha5, 8'h0d);
	end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 t_strobe;
		t_rwline;
		t_muxed;
		test_done;
	end
	initial begin
		#20000;
		error_cnt = error_cnt + 1;
		test_done;
	end
endmodule // hbp_host_port_test
